// ===== hw/acc_pkg.sv
// Package: register map, field layout and timing constants of the converter control block
package acc_pkg;
    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ACC_OFF_CTRL = 8'h08;   // converter_control_primary
    localparam logic [7:0] ACC_OFF_PCFG = 8'h0c;   // port_analog_config
    localparam logic [7:0] ACC_OFF_RES = 8'h10;    // conversion_result
    localparam logic [7:0] ACC_OFF_IST = 8'h14;    // interrupt status
    localparam logic [7:0] ACC_OFF_IMSK = 8'h18;   // interrupt mask
    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int ACC_B_PWR = 0;
    localparam int ACC_B_DONEF = 1;
    localparam int ACC_B_GO = 2;
    localparam int ACC_B_CHS = 3;
    localparam int ACC_B_GPB = 5;
    localparam int ACC_B_CKS = 6;
    localparam logic [7:0] ACC_CTRL_RST = 8'h00;
    localparam logic [2:0] ACC_PCFG_RST = 3'h0;
    // Clock select codes
    localparam logic [1:0] ACC_CKS_DIV2 = 2'h0;
    localparam logic [1:0] ACC_CKS_DIV8 = 2'h1;
    localparam logic [1:0] ACC_CKS_DIV32 = 2'h2;
    localparam logic [1:0] ACC_CKS_RC = 2'h3;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int ACC_DIV2 = 2;
    localparam int ACC_DIV8 = 8;
    localparam int ACC_DIV32 = 32;
    localparam int ACC_RC_DIV = 16;               // internal RC stand-in period in cycles
    localparam int ACC_NBITS = 8;
    localparam int ACC_SETTLE_PERIODS = 2;        // periods after conversion ends
    // Converter state
    typedef enum logic [1:0] {
        ACC_IDLE = 2'b00,
        ACC_CONV = 2'b01,
        ACC_SETTLE = 2'b10
    } acc_state_t;
    // Conversion status carried out of the block
    typedef struct packed {
        logic busy;
        logic settling;
        logic [1:0] channel;
    } acc_status_t;
endpackage

// ===== hw/acc_tad_gen.sv
// Bit conversion period enable generator with selectable divide ratio
`timescale 1ns/1ps
module acc_tad_gen
    import acc_pkg::*;
(
    input wire logic clk_i,        // Core clock
    input wire logic reset_n_i,    // Async reset, active low
    input wire logic run_i,        // Count while high
    input wire logic [1:0] sel_i,  // Clock select code
    output logic tick_o            // One-cycle period pulse
);
    logic [5:0] cnt_r;
    logic [5:0] lim;

    // ------------------------------------------------------------
    // Divide ratio select
    // ------------------------------------------------------------
    always_comb begin
        case (sel_i)
            ACC_CKS_DIV2: lim = 6'(ACC_DIV2 - 1);
            ACC_CKS_DIV8: lim = 6'(ACC_DIV8 - 1);
            ACC_CKS_DIV32: lim = 6'(ACC_DIV32 - 1);
            ACC_CKS_RC: lim = 6'(ACC_RC_DIV - 1);
            default: lim = 6'(ACC_DIV2 - 1);
        endcase
    end

    // Counter restarts when idle so the first period is whole
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_r <= 6'h00;
        end else if (!run_i || cnt_r >= lim) begin
            cnt_r <= 6'h00;
        end else begin
            cnt_r <= cnt_r + 6'h01;
        end
    end

    assign tick_o = run_i && (cnt_r >= lim);
endmodule

// ===== hw/acc_top.sv
// Converter control block: APB registers, SAR sequencer and completion interrupt
`timescale 1ns/1ps
module acc_top
    import acc_pkg::*;
#(
    parameter bit GP_BIT5 = 1'b0   // Variant with general-purpose bit 5
) (
    input wire logic clk_i,                // Core clock, 40 MHz
    input wire logic reset_n_i,            // Async reset, active low
    input wire logic psel,                 // APB select
    input wire logic penable,              // APB enable
    input wire logic pwrite,               // APB direction
    input wire logic [7:0] paddr,          // APB byte address
    input wire logic [31:0] pwdata,        // APB write data
    output logic [31:0] prdata,            // APB read data
    output logic pready,                   // APB ready
    output logic pslverr,                  // APB error
    input wire logic sleep_i,              // Core in sleep
    input wire logic cmp_i,                // Comparator: input at or above DAC, async
    output logic [7:0] dac_o,              // Trial code to DAC
    output logic [1:0] mux_sel_o,          // Analog mux channel
    output logic sample_o,                 // Sample-and-hold tracking
    output logic analog_on_o,              // Analog bias enable
    output logic ref_ext_o,                // Use reference-capable pin
    output logic [3:0] pin_analog_o,       // Per-pin analog enable
    output acc_status_t status_o,          // Sequencer status
    output logic irq_o                     // Interrupt, active high level
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic pwr_r;
    logic go_r;
    logic done_r;
    logic gpb_r;
    logic [1:0] chs_r;
    logic [1:0] cks_r;
    logic [2:0] pcfg_r;
    logic [7:0] res_r;
    logic [7:0] sar_r;
    logic [7:0] trial_r;
    logic [2:0] bit_r;
    logic [1:0] settle_r;
    logic imsk_r;
    acc_state_t state_r;
    acc_state_t state_nxt;
    logic cmp_s1_r;
    logic cmp_s2_r;
    logic tick;
    logic clk_ok;
    logic wr;
    logic rd;
    logic wr_ctrl;
    logic wr_ist;
    logic go_set;
    logic go_clr;
    logic conv_end;
    logic abort;
    logic [7:0] ctrl_rd;
    logic [7:0] sar_bit;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    // Zero wait states; every access completes in its access cycle
    assign pready = 1'b1;
    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign wr_ctrl = wr && (paddr == ACC_OFF_CTRL);
    assign wr_ist = wr && (paddr == ACC_OFF_IST);
    // Unmapped offsets answer with an error and change nothing
    assign pslverr = psel && penable && !(paddr == ACC_OFF_CTRL || paddr == ACC_OFF_PCFG ||
                     paddr == ACC_OFF_RES || paddr == ACC_OFF_IST || paddr == ACC_OFF_IMSK);

    // Go requests from the bus
    assign go_set = wr_ctrl && pwdata[ACC_B_GO] && pwr_r && (state_r == ACC_IDLE);
    assign go_clr = wr_ctrl && !pwdata[ACC_B_GO] && go_r;

    // ------------------------------------------------------------
    // Comparator synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cmp_s1_r <= 1'b0;
            cmp_s2_r <= 1'b0;
        end else begin
            cmp_s1_r <= cmp_i;
            cmp_s2_r <= cmp_s1_r;
        end
    end

    // ------------------------------------------------------------
    // Period generator
    // ------------------------------------------------------------
    // Core clock stops in sleep; only the RC source keeps ticking
    assign clk_ok = !sleep_i || (cks_r == ACC_CKS_RC);

    acc_tad_gen acc_tad_gen_i (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .run_i(pwr_r && (state_r != ACC_IDLE) && clk_ok),
        .sel_i(cks_r),
        .tick_o(tick)
    );

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    assign conv_end = (state_r == ACC_CONV) && tick && (bit_r == 3'h0);
    // Power-off also stops a running conversion
    assign abort = (state_r == ACC_CONV) && (go_clr || !pwr_r);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ACC_IDLE: begin
                if (go_set) begin
                    state_nxt = ACC_CONV;
                end
            end
            ACC_CONV: begin
                if (abort) begin
                    state_nxt = ACC_IDLE;
                end else if (conv_end) begin
                    state_nxt = ACC_SETTLE;
                end
            end
            ACC_SETTLE: begin
                if (!pwr_r || (tick && settle_r == 2'(ACC_SETTLE_PERIODS - 1))) begin
                    state_nxt = ACC_IDLE;
                end
            end
            default: state_nxt = ACC_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_r <= ACC_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Settle period counter
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            settle_r <= 2'h0;
        end else if (state_r != ACC_SETTLE) begin
            settle_r <= 2'h0;
        end else if (tick) begin
            settle_r <= settle_r + 2'h1;
        end
    end

    // One-hot mask of the bit under trial
    assign sar_bit = 8'h01 << bit_r;

    // Successive approximation: keep trial bit if input at or above DAC
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bit_r <= 3'h7;
            sar_r <= 8'h00;
            trial_r <= 8'h80;
        end else if (state_r != ACC_CONV || go_set) begin
            bit_r <= 3'(ACC_NBITS - 1);
            sar_r <= 8'h00;
            trial_r <= 8'h80;
        end else if (tick) begin
            bit_r <= bit_r - 3'h1;
            sar_r <= cmp_s2_r ? trial_r : (trial_r & ~sar_bit);
            trial_r <= (cmp_s2_r ? trial_r : (trial_r & ~sar_bit)) | (sar_bit >> 1);
        end
    end

    // Result captured with the final decision
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            res_r <= 8'h00;
        end else if (conv_end && !abort) begin
            res_r <= cmp_s2_r ? trial_r : (trial_r & 8'hfe);
        end
    end

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pwr_r <= ACC_CTRL_RST[ACC_B_PWR];
            chs_r <= 2'h0;
            cks_r <= 2'h0;
            gpb_r <= 1'b0;
        end else if (wr_ctrl) begin
            pwr_r <= pwdata[ACC_B_PWR];
            chs_r <= pwdata[ACC_B_CHS +: 2];
            cks_r <= pwdata[ACC_B_CKS +: 2];
            gpb_r <= GP_BIT5 & pwdata[ACC_B_GPB];
        end
    end

    // Go flag: set by software, cleared by hardware at end or by software
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            go_r <= 1'b0;
        end else if (go_set) begin
            go_r <= 1'b1;
        end else if (conv_end || abort) begin
            go_r <= 1'b0;
        end
    end

    // Done flag: set wins over a simultaneous clear
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            done_r <= 1'b0;
        end else if (conv_end && !abort) begin
            done_r <= 1'b1;
        end else if (wr_ctrl && !pwdata[ACC_B_DONEF]) begin
            done_r <= 1'b0;
        end else if (wr_ist && pwdata[0]) begin
            done_r <= 1'b0;
        end
    end

    // Port configuration and interrupt mask
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pcfg_r <= ACC_PCFG_RST;
            imsk_r <= 1'b0;
        end else if (wr && paddr == ACC_OFF_PCFG) begin
            pcfg_r <= pwdata[2:0];
        end else if (wr && paddr == ACC_OFF_IMSK) begin
            imsk_r <= pwdata[0];
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Bit 5 reads zero unless the variant keeps a general-purpose bit
    assign ctrl_rd = {cks_r, gpb_r, chs_r, go_r, done_r, pwr_r};

    always_comb begin
        prdata = 32'h0000_0000;
        if (rd) begin
            case (paddr)
                ACC_OFF_CTRL: prdata = {24'h000000, ctrl_rd};
                ACC_OFF_PCFG: prdata = {29'h0000_0000, pcfg_r};
                ACC_OFF_RES: prdata = {24'h000000, res_r};
                ACC_OFF_IST: prdata = {31'h0000_0000, done_r};
                ACC_OFF_IMSK: prdata = {31'h0000_0000, imsk_r};
                default: prdata = 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Analog side
    // ------------------------------------------------------------
    // Pin map: 0 and 1 all analog, 2 pins 0-1 only, 3 all digital; ext ref on code 1 or bit 2
    always_comb begin
        case (pcfg_r[1:0])
            2'h0: pin_analog_o = 4'hf;
            2'h1: pin_analog_o = 4'hf;
            2'h2: pin_analog_o = 4'h3;
            default: pin_analog_o = 4'h0;
        endcase
    end

    assign ref_ext_o = pcfg_r[2] || (pcfg_r[1:0] == 2'h1);
    assign dac_o = trial_r;
    assign mux_sel_o = chs_r;
    assign analog_on_o = pwr_r;
    // Tracking whenever idle and powered; hold during conversion
    assign sample_o = pwr_r && (state_r == ACC_IDLE);
    assign status_o = '{busy: state_r == ACC_CONV, settling: state_r == ACC_SETTLE,
                        channel: chs_r};
    // Level interrupt; stays high until software clears the sticky flag or the mask bit
    assign irq_o = done_r && imsk_r;
endmodule

// ===== sim/acc_top_props.sv
// Checker: port-level properties of the converter control block
`timescale 1ns/1ps
module acc_top_props
    import acc_pkg::*;
#(
    parameter bit GP_BIT5 = 1'b0   // Variant with general-purpose bit 5
) (
    input wire logic clk_i,             // Core clock
    input wire logic reset_n_i,         // Async reset, active low
    input wire logic psel,              // APB select
    input wire logic penable,           // APB enable
    input wire logic pwrite,            // APB direction
    input wire logic [7:0] paddr,       // APB byte address
    input wire logic [31:0] pwdata,     // APB write data
    input wire logic [31:0] prdata,     // APB read data
    input wire logic sleep_i,           // Core in sleep
    input wire logic [7:0] dac_o,       // Trial code
    input wire logic analog_on_o,       // Analog bias enable
    input wire acc_status_t status_o,   // Sequencer status
    input wire logic irq_o              // Interrupt level
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    logic acc_w, wr_ctrl, rd_ctrl, idle;
    logic [1:0] cks_r;
    logic [9:0] busy_cnt_r;
    // Access decode; pready is zero wait, so every access cycle is taken
    assign acc_w = psel && penable && pwrite;
    assign wr_ctrl = acc_w && (paddr == ACC_OFF_CTRL);
    assign rd_ctrl = psel && penable && !pwrite && (paddr == ACC_OFF_CTRL);
    assign idle = !status_o.busy && !status_o.settling;
    // Period length in cycles for a clock select code
    function automatic int per(input logic [1:0] c);
        case (c)
            ACC_CKS_DIV2: return ACC_DIV2;
            ACC_CKS_DIV8: return ACC_DIV8;
            ACC_CKS_DIV32: return ACC_DIV32;
            default: return ACC_RC_DIV;
        endcase
    endfunction
    // Shadow of the clock field and count of advancing busy cycles
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cks_r <= 2'h0;
            busy_cnt_r <= 10'h000;
        end else begin
            if (wr_ctrl) begin
                cks_r <= pwdata[ACC_B_CKS +: 2];
            end
            if (!status_o.busy) begin
                busy_cnt_r <= 10'h000;
            end else if (!sleep_i || cks_r == ACC_CKS_RC) begin
                busy_cnt_r <= busy_cnt_r + 10'h001;
            end
        end
    end
    property p_pwr; wr_ctrl |=> analog_on_o == $past(pwdata[ACC_B_PWR]); endproperty
    a_pwr: assert property (p_pwr) else $error("Power bit not applied");
    property p_off; !analog_on_o |-> !status_o.busy; endproperty
    a_off: assert property (p_off) else $error("Busy while powered off");
    property p_start;
        wr_ctrl && pwdata[ACC_B_GO] && pwdata[ACC_B_PWR] && analog_on_o && idle |=> status_o.busy;
    endproperty
    a_start: assert property (p_start) else $error("Go did not start");
    property p_refuse;
        wr_ctrl && !status_o.busy && (!analog_on_o || status_o.settling) |=> !status_o.busy;
    endproperty
    a_refuse: assert property (p_refuse) else $error("Go not refused");
    property p_rdgo; rd_ctrl && status_o.busy |-> prdata[ACC_B_GO]; endproperty
    a_rdgo: assert property (p_rdgo) else $error("Go reads 0 while busy");
    property p_bit5; rd_ctrl && !GP_BIT5 |-> !prdata[ACC_B_GPB] && prdata[31:8] == 24'h0; endproperty
    a_bit5: assert property (p_bit5) else $error("Unused control bits set");
    property p_len;
        $fell(status_o.busy) && !$past(wr_ctrl) |-> int'(busy_cnt_r) + 2 >= ACC_NBITS * per(cks_r)
            && int'(busy_cnt_r) <= ACC_NBITS * per(cks_r) + 2;
    endproperty
    a_len: assert property (p_len) else $error("Conversion length wrong");
    property p_sleep;
        $past(sleep_i) && $past(status_o.busy) && !$past(wr_ctrl) && cks_r != ACC_CKS_RC
            |-> $stable(dac_o);
    endproperty
    a_sleep: assert property (p_sleep) else $error("Advanced in sleep");
    property p_abort; wr_ctrl && status_o.busy && !pwdata[ACC_B_GO] |=> !status_o.busy; endproperty
    a_abort: assert property (p_abort) else $error("Abort ignored");
    property p_irqr; $rose(irq_o) |-> $past(status_o.busy) || $past(acc_w); endproperty
    a_irqr: assert property (p_irqr) else $error("Interrupt without cause");
    property p_irqf; $fell(irq_o) |-> $past(acc_w); endproperty
    a_irqf: assert property (p_irqf) else $error("Done cleared by hardware");
endmodule

bind acc_top acc_top_props #(.GP_BIT5(GP_BIT5)) acc_top_props_i (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .sleep_i(sleep_i), .dac_o(dac_o),
    .analog_on_o(analog_on_o), .status_o(status_o), .irq_o(irq_o)
);

// ===== sim/acc_analog_model.sv
// Partner model: analog inputs, channel mux and comparator
`timescale 1ns/1ps
module acc_analog_model (
    input wire logic clk_i,            // Core clock
    input wire logic [31:0] vin_i,     // Four input levels, channel 0 lowest
    input wire logic [1:0] mux_sel_i,  // Selected channel
    input wire logic [7:0] dac_i,      // Trial code
    input wire logic analog_on_i,      // Bias enable
    output logic cmp_o                 // Input at or above trial code
);
    logic toggle_r = 1'b0;
    // Unpowered comparator has no stable answer, so it wanders
    always @(posedge clk_i) toggle_r <= !toggle_r;
    // Pins only ever act as inputs here
    // Routed input against trial code
    assign cmp_o = analog_on_i ? (vin_i[mux_sel_i * 8 +: 8] >= dac_i) : toggle_r;
endmodule

// ===== sim/adc_conversion_control_tb_top.sv
// Testbench: conversion, register, interrupt, sleep and abort tests of the converter block
`timescale 1ns/1ps
module adc_conversion_control_tb_top;
    import acc_pkg::*;
    typedef struct packed {
        logic [1:0] cks;
        logic [1:0] chs;
        logic [7:0] vin;
        logic [7:0] res;
    } acc_row_t;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sleep_i = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, vin = 32'h0, prdata, q, tmp;
    logic pready, pslverr, cmp_i, sample_o, analog_on_o, ref_ext_o, irq_o, err;
    logic [7:0] dac_o;
    logic [1:0] mux_sel_o;
    logic [3:0] pin_analog_o;
    acc_status_t status_o;
    int n_fail = 0, n_checks = 0;
    acc_row_t rows [4] = '{'{2'h0, 2'h0, 8'h00, 8'h00}, '{2'h1, 2'h1, 8'hff, 8'hff},
        '{2'h2, 2'h2, 8'h5a, 8'h5a}, '{2'h3, 2'h3, 8'ha5, 8'ha5}};
    logic [7:0] regs [5] = '{ACC_OFF_CTRL, ACC_OFF_PCFG, ACC_OFF_RES, ACC_OFF_IST, ACC_OFF_IMSK};
    // 40 MHz core clock
    always #12.5 clk_i = !clk_i;
    acc_top acc_top_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sleep_i(sleep_i), .cmp_i(cmp_i), .dac_o(dac_o),
        .mux_sel_o(mux_sel_o), .sample_o(sample_o), .analog_on_o(analog_on_o),
        .ref_ext_o(ref_ext_o), .pin_analog_o(pin_analog_o), .status_o(status_o), .irq_o(irq_o));
    acc_analog_model acc_analog_model_i (.clk_i(clk_i), .vin_i(vin), .mux_sel_i(mux_sel_o),
        .dac_i(dac_o), .analog_on_i(analog_on_o), .cmp_o(cmp_i));
    // One APB transfer; data and error taken at the ready edge only
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        do @(posedge clk_i); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic rd(input logic [7:0] a, input string nm, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, exp, q);
    endtask
    // Configure with done cleared, wait for acquisition, then set go
    task automatic conv(input logic [1:0] cks, input logic [1:0] chs);
        apb(1'b1, ACC_OFF_CTRL, {24'h0, cks, 1'b0, chs, 3'b001});
        repeat (80) @(posedge clk_i);
        apb(1'b1, ACC_OFF_CTRL, {24'h0, cks, 1'b0, chs, 3'b101});
    endtask
    // Poll go low; bounded so a stuck flag still ends
    task automatic wait_done();
        apb(1'b0, ACC_OFF_CTRL, 32'h0);
        for (int k = 0; k < 400 && q[ACC_B_GO] !== 1'b0; k++) apb(1'b0, ACC_OFF_CTRL, 32'h0);
        chk("go end", 32'h0, {31'h0, q[ACC_B_GO]});
    endtask
    task automatic results();
        $display("Checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        reset_n_i <= 1'b1;
        apb(1'b1, ACC_OFF_IMSK, 32'h1);
        // Every clock code and channel, other inputs at the inverse level
        foreach (rows[i]) begin
            tmp = {4{~rows[i].vin}};
            tmp[rows[i].chs * 8 +: 8] = rows[i].vin;
            vin <= tmp;
            conv(rows[i].cks, rows[i].chs);
            rd(ACC_OFF_CTRL, "go busy", {24'h0, rows[i].cks, 1'b0, rows[i].chs, 3'b101});
            chk("mux", {30'h0, rows[i].chs}, {30'h0, mux_sel_o});
            chk("status", {28'h0, 2'b10, rows[i].chs}, {28'h0, status_o});
            chk("sample hold", 32'h0, {31'h0, sample_o});
            wait_done();
            rd(ACC_OFF_RES, "result", {24'h0, rows[i].res});
            rd(ACC_OFF_IST, "done", 32'h1);
            chk("irq", 32'h1, {31'h0, irq_o});
            apb(1'b1, ACC_OFF_IST, 32'h1);
            rd(ACC_OFF_IST, "done clr", 32'h0);
            chk("irq clr", 32'h0, {31'h0, irq_o});
            $display("Test row %0d done", i);
        end
        // Refusals: power off, go in the same write as power, go in settle, unmapped
        vin <= 32'h44332211;
        apb(1'b1, ACC_OFF_CTRL, 32'h0);
        rd(ACC_OFF_CTRL, "off", 32'h0);
        chk("bias off", 32'h0, {31'h0, analog_on_o});
        apb(1'b1, ACC_OFF_CTRL, 32'h5);
        rd(ACC_OFF_CTRL, "go unpowered", 32'h1);
        conv(ACC_CKS_DIV32, 2'h0);
        wait_done();
        apb(1'b1, ACC_OFF_CTRL, 32'h87);
        rd(ACC_OFF_CTRL, "go in settle", 32'h83);
        rd(ACC_OFF_RES, "result ch0", 32'h11);
        apb(1'b0, 8'h04, 32'h0);
        chk("slverr", 32'h1, {31'h0, err});
        $display("Test refusals done");
        // Mask hides a sticky flag; write one clears it
        apb(1'b1, ACC_OFF_IMSK, 32'h0);
        repeat (100) @(posedge clk_i);
        chk("irq masked", 32'h0, {31'h0, irq_o});
        apb(1'b1, ACC_OFF_IMSK, 32'h1);
        rd(ACC_OFF_IST, "sticky", 32'h1);
        chk("irq unmasked", 32'h1, {31'h0, irq_o});
        apb(1'b1, ACC_OFF_IST, 32'h1);
        rd(ACC_OFF_IST, "w1c", 32'h0);
        $display("Test interrupt done");
        // Abort mid-conversion keeps result and flag
        conv(ACC_CKS_DIV32, 2'h1);
        repeat (40) @(posedge clk_i);
        apb(1'b1, ACC_OFF_CTRL, 32'h89);
        rd(ACC_OFF_CTRL, "aborted", 32'h89);
        chk("sample track", 32'h1, {31'h0, sample_o});
        rd(ACC_OFF_RES, "result kept", 32'h11);
        rd(ACC_OFF_IST, "flag kept", 32'h0);
        $display("Test abort done");
        // Sleep stalls a divided clock, internal RC clock runs on
        sleep_i <= 1'b1;
        conv(ACC_CKS_DIV8, 2'h1);
        repeat (200) @(posedge clk_i);
        rd(ACC_OFF_CTRL, "stalled", 32'h4d);
        sleep_i <= 1'b0;
        wait_done();
        rd(ACC_OFF_RES, "result ch1", 32'h22);
        sleep_i <= 1'b1;
        conv(ACC_CKS_RC, 2'h2);
        wait_done();
        rd(ACC_OFF_RES, "result sleep", 32'h33);
        sleep_i <= 1'b0;
        $display("Test sleep done");
        // Port configuration codes and reference choice
        for (int p = 0; p < 5; p++) begin
            apb(1'b1, ACC_OFF_PCFG, p);
            rd(ACC_OFF_PCFG, "pcfg", p);
            chk("ref", 32'(p == 1 || p == 4), {31'h0, ref_ext_o});
            chk("pins", p == 2 ? 32'h3 : p == 3 ? 32'h0 : 32'hf, {28'h0, pin_analog_o});
        end
        $display("Test port config done");
        // Reset in mid-conversion returns every register to zero
        conv(ACC_CKS_DIV32, 2'h3);
        reset_n_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        reset_n_i <= 1'b1;
        foreach (regs[r]) rd(regs[r], "reset value", 32'h0);
        chk("dac reset", 32'h80, {24'h0, dac_o});
        chk("irq reset", 32'h0, {31'h0, irq_o});
        $display("Test reset done");
        results();
    end
    // Watchdog well beyond the expected run of a few thousand cycles
    initial begin
        #400000;
        n_fail++;
        $display("FAIL watchdog expected end seen hang");
        results();
    end
endmodule
